// ==== hw/audio_driver_status_agc.v ====
// Driver power-down status, pop sequencing and gain loop limit registers of the audio codec.
// Assumes the host serial port logic turns each transfer into one read or write strobe on this clock.
//
// Notes on behaviour
// - Six read-only bits D15..D10 show each output driver powered down; reset 1.
// - Bit D9 at 0 enables headphone pop reduction, 1 disables; reset 0.
// - Bit D8 at 0 routes the buzzer input to the buzzer gain stage; reset 0.
// - Bit D7 at 1 routes speaker two to the buzzer gain stage; reset 0.
// - Bit D6 at 1 routes speaker one to the buzzer gain stage; reset 0.
// - Bit D5 at 0 enables speaker, handset and ground driver pop sequencing; reset 0.
// - Capacitor-coupled pop sequence lasts 802 ms with D4 at 0, 4006 ms at 1.
// - Low reserved bits read zero; software writes only zeros there.
// - Mic gain ceiling field D15..D9, half dB steps from 0 dB; reset all ones.
// - Mic normal-to-silence debounce code at D8..D6 selects 0 to 32 ms.
// - Mic silence-to-normal debounce code at D5..D3 selects 0 to 32 ms.
// - Cellular gain ceiling: -34.5 dB up by half dB, invalid band, 11xxxxx gives 12 dB.
// - Cellular normal-to-silence debounce at D8..D6 is read-only, reset 000.
// - Cellular silence-to-normal debounce at D5..D3 is read-only, reset 000.
// - Shared noise threshold: codes 0 and 1 mean -30 dB, then 10 dB lower each.
`timescale 1ns/10ps
`include "audio_driver_status_agc_regs.vh"

module audio_driver_status_agc #(
  parameter [31:0] POP_SHORT_CYCLES = `POP_SHORT_MS * `CLOCK_KHZ,
  parameter [31:0] POP_LONG_CYCLES = `POP_LONG_MS * `CLOCK_KHZ,
  parameter [31:0] HALF_MS_CYCLES = `HALF_MS_US * `CLOCK_MHZ
) (
  input wire CLOCK_I,
  input wire RST_I,
  input wire [7:0] REG_ADDR_I,
  input wire REG_WRITE_I,
  input wire REG_READ_I,
  input wire [15:0] REG_WDATA_I,
  output reg [15:0] REG_RDATA_O,
  output reg REG_RVALID_O,
  input wire [5:0] DRIVER_OFF_I,
  input wire POP_SEQUENCE_REQUEST_I,
  input wire CAP_COUPLED_MODE_I,
  output wire POP_SEQUENCE_BUSY_O,
  output reg POP_SEQUENCE_DONE_O,
  output wire HEADPHONE_POP_REDUCE_EN_O,
  output wire BUZZER_INPUT_ROUTE_EN_O,
  output wire SPEAKER_TWO_ROUTE_EN_O,
  output wire SPEAKER_ONE_ROUTE_EN_O,
  output wire [6:0] MIC_GAIN_CEILING_O,
  output wire [6:0] CELLULAR_GAIN_CEILING_O,
  output wire CELLULAR_CEILING_INVALID_O,
  output wire CELLULAR_CEILING_TOP_O,
  input wire [2:0] GAIN_LOOP_NOISE_THRESHOLD_I,
  input wire [6:0] MIC_LEVEL_ATTEN_DB_I,
  input wire [6:0] CELLULAR_LEVEL_ATTEN_DB_I,
  output wire [6:0] NOISE_THRESHOLD_ATTEN_DB_O,
  output wire MIC_SILENCE_O,
  output wire CELLULAR_SILENCE_O
);

  // Driver flag order from bit 15 down: speaker one, speaker two, handset,
  // virtual ground, loudspeaker, cellular output.
  reg [5:0] flag_meta;
  reg [5:0] flag_sync;
  reg [5:0] flag_late;
  reg [5:0] driver_off_flags;
  reg headphone_pop_reduce_disable;
  reg buzzer_route_disable;
  reg speaker_two_to_buzzer_route;
  reg speaker_one_to_buzzer_route;
  reg driver_pop_sequence_disable;
  reg pop_sequence_duration_select;
  reg [6:0] mic_gain_ceiling;
  reg [2:0] mic_to_silence_debounce;
  reg [2:0] mic_to_normal_debounce;
  reg [6:0] cellular_gain_ceiling;
  reg [2:0] cellular_to_silence_debounce;
  reg [2:0] cellular_to_normal_debounce;
  reg pop_busy;
  reg [31:0] pop_count;
  reg [31:0] pop_limit;
  reg [31:0] tick_count;
  reg half_ms_tick;
  reg [15:0] next_rdata;
  wire [5:0] speaker_one_off_flag_etc;
  wire [6:0] threshold_db;
  wire [2:0] mic_silence_code;

  // Attenuation below full scale of the shared silence threshold, in dB.
  function [6:0] noise_threshold_db;
    input [2:0] code;
    begin
      if (code <= 3'h1) begin
        noise_threshold_db = `NOISE_THRESHOLD_TOP_DB;
      end else begin
        noise_threshold_db = `NOISE_THRESHOLD_TOP_DB + ({4'h0, code} - 7'h01) * `NOISE_THRESHOLD_STEP_DB;
      end
    end
  endfunction

  assign threshold_db = noise_threshold_db(GAIN_LOOP_NOISE_THRESHOLD_I);
  assign NOISE_THRESHOLD_ATTEN_DB_O = threshold_db;
  assign speaker_one_off_flag_etc = driver_off_flags;

  // The mic normal-to-silence scale has no 16 ms step, so code 110 times out like 101 at 8 ms.
  assign mic_silence_code = (mic_to_silence_debounce == 3'h6) ? 3'h5 : mic_to_silence_debounce;

  // The driver flags come from analog power-down detectors on another timebase.
  // A flag changes only once the second and third stages agree, so a single metastable sample cannot leak in.
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      flag_meta <= `DRV_FLAGS_RESET;
      flag_sync <= `DRV_FLAGS_RESET;
      flag_late <= `DRV_FLAGS_RESET;
      driver_off_flags <= `DRV_FLAGS_RESET;
    end else begin
      flag_meta <= DRIVER_OFF_I;
      flag_sync <= flag_meta;
      flag_late <= flag_sync;
      driver_off_flags <= (flag_sync & flag_late) | (driver_off_flags & (flag_sync | flag_late));
    end
  end

  // Register writes. Status and cellular debounce fields and reserved bits take no write data.
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      headphone_pop_reduce_disable <= `DRV_CONTROL_RESET;
      buzzer_route_disable <= `DRV_CONTROL_RESET;
      speaker_two_to_buzzer_route <= `DRV_CONTROL_RESET;
      speaker_one_to_buzzer_route <= `DRV_CONTROL_RESET;
      driver_pop_sequence_disable <= `DRV_CONTROL_RESET;
      pop_sequence_duration_select <= `DRV_CONTROL_RESET;
      mic_gain_ceiling <= `CEILING_RESET;
      mic_to_silence_debounce <= `DEBOUNCE_RESET;
      mic_to_normal_debounce <= `DEBOUNCE_RESET;
      cellular_gain_ceiling <= `CEILING_RESET;
      cellular_to_silence_debounce <= `DEBOUNCE_RESET;
      cellular_to_normal_debounce <= `DEBOUNCE_RESET;
    end else if (REG_WRITE_I) begin
      if (REG_ADDR_I == `DRIVER_POWERDOWN_STATUS_ADDR) begin
        headphone_pop_reduce_disable <= REG_WDATA_I[`DRV_POP_REDUCE_BIT];
        buzzer_route_disable <= REG_WDATA_I[`DRV_BUZZER_ROUTE_BIT];
        speaker_two_to_buzzer_route <= REG_WDATA_I[`DRV_SPEAKER_TWO_DRIVER_ROUTE_BIT];
        speaker_one_to_buzzer_route <= REG_WDATA_I[`DRV_SPEAKER_ONE_DRIVER_ROUTE_BIT];
        driver_pop_sequence_disable <= REG_WDATA_I[`DRV_POP_SEQ_BIT];
        pop_sequence_duration_select <= REG_WDATA_I[`DRV_POP_TIME_BIT];
      end else if (REG_ADDR_I == `MIC_GAIN_LOOP_CONTROL_ADDR) begin
        mic_gain_ceiling <= REG_WDATA_I[`CEILING_MSB:`CEILING_LSB];
        mic_to_silence_debounce <= REG_WDATA_I[`TO_SILENCE_MSB:`TO_SILENCE_LSB];
        mic_to_normal_debounce <= REG_WDATA_I[`TO_NORMAL_MSB:`TO_NORMAL_LSB];
      end else if (REG_ADDR_I == `CELLULAR_GAIN_LOOP_CONTROL_ADDR) begin
        // The debounce fields of this register are read-only and keep their value.
        cellular_gain_ceiling <= REG_WDATA_I[`CEILING_MSB:`CEILING_LSB];
      end
    end
  end

  // Read data; unmapped addresses return zero.
  always @* begin
    next_rdata = 16'h0000;
    if (REG_ADDR_I == `DRIVER_POWERDOWN_STATUS_ADDR) begin
      next_rdata[`DRV_FLAGS_MSB:`DRV_FLAGS_LSB] = speaker_one_off_flag_etc;
      next_rdata[`DRV_POP_REDUCE_BIT] = headphone_pop_reduce_disable;
      next_rdata[`DRV_BUZZER_ROUTE_BIT] = buzzer_route_disable;
      next_rdata[`DRV_SPEAKER_TWO_DRIVER_ROUTE_BIT] = speaker_two_to_buzzer_route;
      next_rdata[`DRV_SPEAKER_ONE_DRIVER_ROUTE_BIT] = speaker_one_to_buzzer_route;
      next_rdata[`DRV_POP_SEQ_BIT] = driver_pop_sequence_disable;
      next_rdata[`DRV_POP_TIME_BIT] = pop_sequence_duration_select;
    end else if (REG_ADDR_I == `MIC_GAIN_LOOP_CONTROL_ADDR) begin
      next_rdata[`CEILING_MSB:`CEILING_LSB] = mic_gain_ceiling;
      next_rdata[`TO_SILENCE_MSB:`TO_SILENCE_LSB] = mic_to_silence_debounce;
      next_rdata[`TO_NORMAL_MSB:`TO_NORMAL_LSB] = mic_to_normal_debounce;
    end else if (REG_ADDR_I == `CELLULAR_GAIN_LOOP_CONTROL_ADDR) begin
      next_rdata[`CEILING_MSB:`CEILING_LSB] = cellular_gain_ceiling;
      next_rdata[`TO_SILENCE_MSB:`TO_SILENCE_LSB] = cellular_to_silence_debounce;
      next_rdata[`TO_NORMAL_MSB:`TO_NORMAL_LSB] = cellular_to_normal_debounce;
    end
  end

  // Reserved low bits are never stored, so they always read back as zero.
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 16'h0000;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_READ_I;
      if (REG_READ_I) begin
        REG_RDATA_O <= next_rdata;
      end
    end
  end

  assign HEADPHONE_POP_REDUCE_EN_O = !headphone_pop_reduce_disable;
  assign BUZZER_INPUT_ROUTE_EN_O = !buzzer_route_disable;
  assign SPEAKER_TWO_ROUTE_EN_O = speaker_two_to_buzzer_route;
  assign SPEAKER_ONE_ROUTE_EN_O = speaker_one_to_buzzer_route;
  assign MIC_GAIN_CEILING_O = mic_gain_ceiling;

  // Codes above the invalid band all saturate at the 12 dB ceiling.
  assign CELLULAR_GAIN_CEILING_O = cellular_gain_ceiling;
  assign CELLULAR_CEILING_INVALID_O = (cellular_gain_ceiling > `CELL_CEILING_LAST_VALID) &&
                                      (cellular_gain_ceiling <= `CELL_CEILING_LAST_INVALID);
  assign CELLULAR_CEILING_TOP_O = cellular_gain_ceiling > `CELL_CEILING_LAST_INVALID;

  // Pop sequence timer. The duration is latched at the request so a later
  // register write cannot stretch or cut a sequence already under way.
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      pop_busy <= 1'b0;
      pop_count <= 32'h00000000;
      pop_limit <= 32'h00000000;
      POP_SEQUENCE_DONE_O <= 1'b0;
    end else begin
      POP_SEQUENCE_DONE_O <= 1'b0;
      if (pop_busy) begin
        if (pop_count >= pop_limit - 32'h00000001) begin
          pop_busy <= 1'b0;
          POP_SEQUENCE_DONE_O <= 1'b1;
        end else begin
          pop_count <= pop_count + 32'h00000001;
        end
      end else if (POP_SEQUENCE_REQUEST_I) begin
        if (driver_pop_sequence_disable || !CAP_COUPLED_MODE_I) begin
          POP_SEQUENCE_DONE_O <= 1'b1;
        end else begin
          pop_busy <= 1'b1;
          pop_count <= 32'h00000000;
          pop_limit <= pop_sequence_duration_select ? POP_LONG_CYCLES : POP_SHORT_CYCLES;
        end
      end
    end
  end

  assign POP_SEQUENCE_BUSY_O = pop_busy;

  // Half millisecond enable for the debounce counters.
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      tick_count <= 32'h00000000;
      half_ms_tick <= 1'b0;
    end else if (tick_count >= HALF_MS_CYCLES - 32'h00000001) begin
      tick_count <= 32'h00000000;
      half_ms_tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h00000001;
      half_ms_tick <= 1'b0;
    end
  end

  gain_loop_silence_debounce mic_silence (
    .clock_i(CLOCK_I),
    .reset_i(RST_I),
    .half_ms_tick_i(half_ms_tick),
    .below_threshold_i(MIC_LEVEL_ATTEN_DB_I > threshold_db),
    .to_silence_code_i(mic_silence_code),
    .to_normal_code_i(mic_to_normal_debounce),
    .silence_o(MIC_SILENCE_O)
  );

  gain_loop_silence_debounce cellular_silence (
    .clock_i(CLOCK_I),
    .reset_i(RST_I),
    .half_ms_tick_i(half_ms_tick),
    .below_threshold_i(CELLULAR_LEVEL_ATTEN_DB_I > threshold_db),
    .to_silence_code_i(cellular_to_silence_debounce),
    .to_normal_code_i(cellular_to_normal_debounce),
    .silence_o(CELLULAR_SILENCE_O)
  );

endmodule

// ==== hw/audio_driver_status_agc_regs.vh ====
// Register offsets, field positions, reset values and timing constants of the driver status and gain loop registers.
// Assumes inclusion by bare name from the design files of this block only.
`ifndef AUDIO_DRIVER_STATUS_AGC_REGS_VH
`define AUDIO_DRIVER_STATUS_AGC_REGS_VH

`define DRIVER_POWERDOWN_STATUS_ADDR 8'h25
`define MIC_GAIN_LOOP_CONTROL_ADDR 8'h26
`define CELLULAR_GAIN_LOOP_CONTROL_ADDR 8'h27

`define DRV_FLAGS_MSB 15
`define DRV_FLAGS_LSB 10
`define DRV_FLAGS_RESET 6'h3f
`define DRV_POP_REDUCE_BIT 9
`define DRV_BUZZER_ROUTE_BIT 8
`define DRV_SPEAKER_TWO_DRIVER_ROUTE_BIT 7
`define DRV_SPEAKER_ONE_DRIVER_ROUTE_BIT 6
`define DRV_POP_SEQ_BIT 5
`define DRV_POP_TIME_BIT 4
`define DRV_CONTROL_RESET 1'h0

`define CEILING_MSB 15
`define CEILING_LSB 9
`define CEILING_RESET 7'h7f
`define TO_SILENCE_MSB 8
`define TO_SILENCE_LSB 6
`define TO_NORMAL_MSB 5
`define TO_NORMAL_LSB 3
`define DEBOUNCE_RESET 3'h0

`define CELL_CEILING_LAST_VALID 7'h44
`define CELL_CEILING_LAST_INVALID 7'h5c

`define NOISE_THRESHOLD_TOP_DB 7'h1e
`define NOISE_THRESHOLD_STEP_DB 7'h0a

`define CLOCK_KHZ 125000
`define CLOCK_MHZ 125
`define POP_SHORT_MS 802
`define POP_LONG_MS 4006
`define HALF_MS_US 500

`endif

// ==== hw/gain_loop_silence_debounce.v ====
// Silence detector of one gain loop: debounces the below-threshold decision in both directions.
// Assumes a one-cycle tick every half millisecond and level inputs on the same clock.
`timescale 1ns/10ps
`include "audio_driver_status_agc_regs.vh"

module gain_loop_silence_debounce (
  input wire clock_i,
  input wire reset_i,
  input wire half_ms_tick_i,
  input wire below_threshold_i,
  input wire [2:0] to_silence_code_i,
  input wire [2:0] to_normal_code_i,
  output reg silence_o
);

  reg [6:0] count;
  wire [6:0] limit;
  wire changing;

  // Debounce time in half milliseconds: 0, 0.5, 1, 2, 4, 8, 16 and 32 ms.
  function [6:0] debounce_half_ms;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        debounce_half_ms = 7'h00;
      end else begin
        debounce_half_ms = 7'h01 << (code - 3'h1);
      end
    end
  endfunction

  assign changing = below_threshold_i != silence_o;
  assign limit = silence_o ? debounce_half_ms(to_normal_code_i) : debounce_half_ms(to_silence_code_i);

  always @(posedge clock_i) begin
    if (reset_i) begin
      count <= 7'h00;
      silence_o <= 1'b0;
    end else if (!changing) begin
      count <= 7'h00;
    end else if (count >= limit) begin
      // A zero debounce code flips on the first cycle of the change.
      count <= 7'h00;
      silence_o <= below_threshold_i;
    end else if (half_ms_tick_i) begin
      count <= count + 7'h01;
    end
  end

endmodule

// ==== testbench/audio_driver_status_agc_assertions.sv ====
// Concurrent checks on the ports of the driver status and gain loop register block.
// Assumes one clock with a synchronous active-high reset; bound to the top module below.
`timescale 1ns/10ps
module audio_driver_status_agc_assertions (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WRITE_I,
  input wire logic REG_READ_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic POP_SEQUENCE_REQUEST_I,
  input wire logic CAP_COUPLED_MODE_I,
  input wire logic POP_SEQUENCE_BUSY_O,
  input wire logic POP_SEQUENCE_DONE_O,
  input wire logic HEADPHONE_POP_REDUCE_EN_O,
  input wire logic BUZZER_INPUT_ROUTE_EN_O,
  input wire logic SPEAKER_TWO_ROUTE_EN_O,
  input wire logic SPEAKER_ONE_ROUTE_EN_O,
  input wire logic [6:0] MIC_GAIN_CEILING_O,
  input wire logic [6:0] CELLULAR_GAIN_CEILING_O,
  input wire logic CELLULAR_CEILING_INVALID_O,
  input wire logic CELLULAR_CEILING_TOP_O,
  input wire logic [2:0] GAIN_LOOP_NOISE_THRESHOLD_I,
  input wire logic [6:0] NOISE_THRESHOLD_ATTEN_DB_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  property p_read_answer; 1 |=> REG_RVALID_O == $past(REG_READ_I); endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late or extra");
  property p_ctrl_write;
    REG_WRITE_I && REG_ADDR_I == 8'h25 |=> HEADPHONE_POP_REDUCE_EN_O == !$past(REG_WDATA_I[9])
      && BUZZER_INPUT_ROUTE_EN_O == !$past(REG_WDATA_I[8]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("pop reduce or buzzer enable wrong");
  property p_route_write;
    REG_WRITE_I && REG_ADDR_I == 8'h25 |=> {SPEAKER_TWO_ROUTE_EN_O, SPEAKER_ONE_ROUTE_EN_O} == $past(REG_WDATA_I[7:6]);
  endproperty
  a_route_write: assert property (p_route_write) else $error("speaker route enable wrong");
  property p_mic_ceiling;
    REG_WRITE_I && REG_ADDR_I == 8'h26 |=> MIC_GAIN_CEILING_O == $past(REG_WDATA_I[15:9]);
  endproperty
  a_mic_ceiling: assert property (p_mic_ceiling) else $error("mic ceiling not taken");
  property p_cell_code;
    CELLULAR_CEILING_INVALID_O == (CELLULAR_GAIN_CEILING_O >= 7'h45 && CELLULAR_GAIN_CEILING_O <= 7'h5c)
      && CELLULAR_CEILING_TOP_O == (CELLULAR_GAIN_CEILING_O > 7'h5c);
  endproperty
  a_cell_code: assert property (p_cell_code) else $error("cellular ceiling decode wrong");
  property p_reserved_zero; REG_READ_I && REG_ADDR_I == 8'h26 |=> REG_RDATA_O[2:0] == 3'h0; endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
  property p_cell_ro; REG_READ_I && REG_ADDR_I == 8'h27 |=> REG_RDATA_O[8:0] == 9'h000; endproperty
  a_cell_ro: assert property (p_cell_ro) else $error("cellular debounce fields not zero");
  property p_threshold;
    NOISE_THRESHOLD_ATTEN_DB_O == (GAIN_LOOP_NOISE_THRESHOLD_I < 3'h2 ? 7'h1e
      : 7'h14 + 7'h0a * {4'h0, GAIN_LOOP_NOISE_THRESHOLD_I});
  endproperty
  a_threshold: assert property (p_threshold) else $error("noise threshold wrong");
  property p_pop_now;
    POP_SEQUENCE_REQUEST_I && !POP_SEQUENCE_BUSY_O && !CAP_COUPLED_MODE_I |=> POP_SEQUENCE_DONE_O && !POP_SEQUENCE_BUSY_O;
  endproperty
  a_pop_now: assert property (p_pop_now) else $error("capless pop not immediate");
  property p_pop_end; !$past(RST_I) && $fell(POP_SEQUENCE_BUSY_O) |-> POP_SEQUENCE_DONE_O; endproperty
  a_pop_end: assert property (p_pop_end) else $error("pop end without done");
endmodule

bind audio_driver_status_agc audio_driver_status_agc_assertions i_audio_driver_status_agc_assertions (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I), .REG_WRITE_I(REG_WRITE_I), .REG_READ_I(REG_READ_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
  .POP_SEQUENCE_REQUEST_I(POP_SEQUENCE_REQUEST_I), .CAP_COUPLED_MODE_I(CAP_COUPLED_MODE_I),
  .POP_SEQUENCE_BUSY_O(POP_SEQUENCE_BUSY_O), .POP_SEQUENCE_DONE_O(POP_SEQUENCE_DONE_O),
  .HEADPHONE_POP_REDUCE_EN_O(HEADPHONE_POP_REDUCE_EN_O), .BUZZER_INPUT_ROUTE_EN_O(BUZZER_INPUT_ROUTE_EN_O),
  .SPEAKER_TWO_ROUTE_EN_O(SPEAKER_TWO_ROUTE_EN_O), .SPEAKER_ONE_ROUTE_EN_O(SPEAKER_ONE_ROUTE_EN_O),
  .MIC_GAIN_CEILING_O(MIC_GAIN_CEILING_O), .CELLULAR_GAIN_CEILING_O(CELLULAR_GAIN_CEILING_O),
  .CELLULAR_CEILING_INVALID_O(CELLULAR_CEILING_INVALID_O), .CELLULAR_CEILING_TOP_O(CELLULAR_CEILING_TOP_O),
  .GAIN_LOOP_NOISE_THRESHOLD_I(GAIN_LOOP_NOISE_THRESHOLD_I), .NOISE_THRESHOLD_ATTEN_DB_O(NOISE_THRESHOLD_ATTEN_DB_O));

// ==== testbench/serial_host_model.sv ====
// Host software model: issues register reads and writes as one-cycle strobes.
// Assumes the strobe port of the block stands in for the serial port.
`timescale 1ns/10ps
module serial_host_model (
  input wire logic clock_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output logic [7:0] addr_o,
  output logic write_o,
  output logic read_o,
  output logic [15:0] wdata_o
);
  initial begin
    addr_o = 8'h00;
    write_o = 1'b0;
    read_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // Callers keep reserved low bits zero, as software must.
  // Status reads are trusted as-is: this host never sees a short circuit reported.
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    @(posedge clock_i) #1;
    addr_o = addr;
    wdata_o = data;
    write_o = 1'b1;
    @(posedge clock_i) #1;
    write_o = 1'b0;
    wdata_o = ~data;
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    @(posedge clock_i) #1;
    addr_o = addr;
    read_o = 1'b1;
    @(posedge clock_i) #1;
    read_o = 1'b0;
    data = rdata_i;
    ok = (rvalid_i === 1'b1);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the driver status and gain loop register block.
// Assumes shortened pop and half-millisecond counts set below.
`timescale 1ns/10ps
module tb_top;
  logic clock = 1'b0, rst = 1'b1, pop_req = 1'b0, cap = 1'b1;
  logic [5:0] drv_off = 6'h3f;
  logic [2:0] thr = 3'h0;
  logic [6:0] mic_lvl = 7'h00, cell_lvl = 7'h00;
  logic [7:0] addr;
  logic wr, rd, rvalid, busy, done, pop_en, buz_en, sp2_en, sp1_en, cinv, ctop, msil, csil, ok;
  logic [15:0] wdata, rdata, v;
  logic [6:0] mceil, cceil, thr_db;
  int n_mismatch = 0, checks = 0, n;
  logic [6:0] codes [5] = '{7'h44, 7'h45, 7'h5c, 7'h5d, 7'h60};
  always #4 clock = ~clock;
  audio_driver_status_agc #(.POP_SHORT_CYCLES(32'd20), .POP_LONG_CYCLES(32'd50), .HALF_MS_CYCLES(32'd4))
    i_audio_driver_status_agc (.CLOCK_I(clock), .RST_I(rst), .REG_ADDR_I(addr), .REG_WRITE_I(wr), .REG_READ_I(rd),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .DRIVER_OFF_I(drv_off),
    .POP_SEQUENCE_REQUEST_I(pop_req), .CAP_COUPLED_MODE_I(cap), .POP_SEQUENCE_BUSY_O(busy),
    .POP_SEQUENCE_DONE_O(done), .HEADPHONE_POP_REDUCE_EN_O(pop_en), .BUZZER_INPUT_ROUTE_EN_O(buz_en),
    .SPEAKER_TWO_ROUTE_EN_O(sp2_en), .SPEAKER_ONE_ROUTE_EN_O(sp1_en), .MIC_GAIN_CEILING_O(mceil),
    .CELLULAR_GAIN_CEILING_O(cceil), .CELLULAR_CEILING_INVALID_O(cinv), .CELLULAR_CEILING_TOP_O(ctop),
    .GAIN_LOOP_NOISE_THRESHOLD_I(thr), .MIC_LEVEL_ATTEN_DB_I(mic_lvl), .CELLULAR_LEVEL_ATTEN_DB_I(cell_lvl),
    .NOISE_THRESHOLD_ATTEN_DB_O(thr_db), .MIC_SILENCE_O(msil), .CELLULAR_SILENCE_O(csil));
  serial_host_model i_serial_host_model (.clock_i(clock), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .write_o(wr), .read_o(rd), .wdata_o(wdata));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    i_serial_host_model.read_reg(a, v, ok);
    check("read valid", {15'h0, ok}, 16'h0001);
    check("read data", v, exp);
  endtask
  // Returns busy cycles of one pop request.
  task automatic pop_run(output int busy_n);
    @(posedge clock) #1 pop_req = 1'b1;
    @(posedge clock) #1 pop_req = 1'b0;
    busy_n = 0;
    for (int i = 0; i < 100 && done !== 1'b1; i++) begin
      busy_n += (busy === 1'b1);
      @(posedge clock) #1;
    end
    check("pop done", {15'h0, done}, 16'h0001);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    rd_chk(8'h25, 16'hfc00);
    rd_chk(8'h26, 16'hfe00);
    rd_chk(8'h27, 16'hfe00);
    check("route outputs", {pop_en, buz_en, sp2_en, sp1_en}, 16'h000c);
    $display("test reset done");
    drv_off = 6'h25;
    i_serial_host_model.write_reg(8'h25, 16'hfff0);
    repeat (6) @(posedge clock);
    rd_chk(8'h25, 16'h97f0);
    check("route outputs", {pop_en, buz_en, sp2_en, sp1_en}, 16'h0003);
    $display("test driver register done");
    i_serial_host_model.write_reg(8'h26, 16'hfff8);
    rd_chk(8'h26, 16'hfff8);
    i_serial_host_model.write_reg(8'h26, 16'h0000);
    rd_chk(8'h26, 16'h0000);
    check("mic ceiling", {9'h0, mceil}, 16'h0000);
    foreach (codes[i]) begin
      i_serial_host_model.write_reg(8'h27, {codes[i], 9'h1f8});
      rd_chk(8'h27, {codes[i], 9'h000});
      check("cell ceiling", {9'h0, cceil}, {9'h0, codes[i]});
      check("cell decode", {cinv, ctop}, (codes[i] > 7'h5c) ? 16'h1 : (codes[i] > 7'h44) ? 16'h2 : 16'h0);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clock) #1 thr = i;
      #1 check("threshold", {9'h0, thr_db}, (i < 2) ? 16'd30 : 16'd30 + 16'd10 * (i - 1));
    end
    thr = 3'h0;
    $display("test gain fields done");
    i_serial_host_model.write_reg(8'h25, 16'h0000);
    pop_run(n);
    check("short pop", n, 16'd20);
    i_serial_host_model.write_reg(8'h25, 16'h0010);
    pop_run(n);
    check("long pop", n, 16'd50);
    i_serial_host_model.write_reg(8'h25, 16'h0030);
    pop_run(n);
    check("pop off", n, 16'd0);
    cap = 1'b0;
    i_serial_host_model.write_reg(8'h25, 16'h0000);
    pop_run(n);
    check("capless pop", n, 16'd0);
    $display("test pop done");
    i_serial_host_model.write_reg(8'h26, 16'hffc0);
    mic_lvl = 7'd40;
    cell_lvl = 7'd40;
    repeat (200) @(posedge clock);
    check("mic early", {15'h0, msil}, 16'h0000);
    check("cell silence", {15'h0, csil}, 16'h0001);
    repeat (70) @(posedge clock);
    check("mic silence", {15'h0, msil}, 16'h0001);
    mic_lvl = 7'd10;
    repeat (3) @(posedge clock);
    check("mic normal", {15'h0, msil}, 16'h0000);
    // Code 110 must time out at 8 ms, which is 16 ticks of 4 cycles here.
    i_serial_host_model.write_reg(8'h26, 16'hff80);
    mic_lvl = 7'd40;
    repeat (56) @(posedge clock);
    check("mic 8 ms early", {15'h0, msil}, 16'h0000);
    repeat (16) @(posedge clock);
    check("mic 8 ms silence", {15'h0, msil}, 16'h0001);
    $display("test silence done");
    end_sim();
  end
endmodule
